// File: core/pmcrb_consts.svh
`ifndef PMCRB_CONSTS_SVH
`define PMCRB_CONSTS_SVH

// ******************************
// register addresses
// ******************************
`define PMCRB_A_MASK    8'h25
`define PMCRB_A_RESET   8'h30
`define PMCRB_A_PROD    8'h31
`define PMCRB_A_REV     8'h32
`define PMCRB_A_FEAT    8'h33
`define PMCRB_A_EN      8'h34
`define PMCRB_A_DIS     8'h35

// ******************************
// reset values and writable bits
// ******************************
`define PMCRB_D_MASK    8'hFF
`define PMCRB_D_RESET   8'h10
`define PMCRB_D_EN      8'h3E
`define PMCRB_D_DIS     8'h00
`define PMCRB_W_RESET   8'h13
`define PMCRB_W_EN      8'h3F
`define PMCRB_W_DIS     8'h1F
`define PMCRB_EN_PWR    8'h3E

// ******************************
// field positions and codes
// ******************************
`define PMCRB_B_FORCE   7
`define PMCRB_B_RSTST   4
`define PMCRB_B_MODE    0
`define PMCRB_B_BUCK    1
`define PMCRB_POL_DEF   2'b00
`define PMCRB_POL_KEEP  2'b01
`define PMCRB_POL_OFF   2'b10
`define PMCRB_NFAULT    8
`define PMCRB_NFUSE     8
`define PMCRB_FUSE_WAIT 2'h3

// ******************************
// serial port
// ******************************
`define PMCRB_I2C_ADDR  7'h2C
`define PMCRB_BYTE_BITS 4'h8
`define PMCRB_PROD_ID   8'h5A
`define PMCRB_REV_ID    8'h01

`endif

// File: core/pmcrb_pkg.sv
package pmcrb_pkg;

  typedef enum logic [9:0] {
    PMCRB_I_IDLE  = 10'h001,
    PMCRB_I_ADDR  = 10'h002,
    PMCRB_I_ACKA  = 10'h004,
    PMCRB_I_REG   = 10'h008,
    PMCRB_I_ACKR  = 10'h010,
    PMCRB_I_WDATA = 10'h020,
    PMCRB_I_ACKW  = 10'h040,
    PMCRB_I_RDATA = 10'h080,
    PMCRB_I_MACK  = 10'h100,
    PMCRB_I_RWAIT = 10'h200
  } pmcrb_i2c_e;

  typedef enum logic [2:0] {
    PMCRB_T_RUN   = 3'h1,
    PMCRB_T_SHUT  = 3'h2,
    PMCRB_T_LATCH = 3'h4
  } pmcrb_tsd_e;

endpackage : pmcrb_pkg

// File: core/pmcrb_sync.sv
`timescale 1ns/100ps
module pmcrb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  import pmcrb_pkg::*;

  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_chk
    $error("pmcrb_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule : pmcrb_sync

// File: core/pmcrb_i2c_slave.sv
`timescale 1ns/100ps
`include "pmcrb_consts.svh"
module pmcrb_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = `PMCRB_I2C_ADDR
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [7:0] rdata_i,
  output logic            sda_oe_o,
  output logic            wr_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o
);
  import pmcrb_pkg::*;

  pmcrb_i2c_e st;
  logic       scl_q;
  logic       sda_q;
  logic [7:0] sh;
  logic [3:0] cnt;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;

  assign rise  = scl_i & ~scl_q;
  assign fall  = ~scl_i & scl_q;
  assign start = scl_i & scl_q & sda_q & ~sda_i;
  assign stop  = scl_i & scl_q & ~sda_q & sda_i;
  assign wdata_o = sh;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // ******************************
  // byte engine: data changes on scl fall, sampled on scl rise
  // ******************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st       <= PMCRB_I_IDLE;
      sh       <= 8'h00;
      cnt      <= 4'h0;
      addr_o   <= 8'h00;
      sda_oe_o <= 1'b0;
      wr_o     <= 1'b0;
    end else begin
      wr_o <= 1'b0;
      if (start) begin
        st       <= PMCRB_I_ADDR;
        cnt      <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop) begin
        st       <= PMCRB_I_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        unique case (st)
          PMCRB_I_IDLE: begin
          end
          PMCRB_I_ADDR, PMCRB_I_REG, PMCRB_I_WDATA: begin
            if (rise) begin
              sh  <= {sh[6:0], sda_i};
              cnt <= cnt + 4'h1;
            end else if (fall && cnt == `PMCRB_BYTE_BITS) begin
              sda_oe_o <= 1'b1;
              if (st == PMCRB_I_ADDR) begin
                // foreign address: let the bus go and wait for the next start
                sda_oe_o <= (sh[7:1] == DEV_ADDR);
                st <= (sh[7:1] == DEV_ADDR) ? PMCRB_I_ACKA : PMCRB_I_IDLE;
              end else if (st == PMCRB_I_REG) begin
                addr_o <= sh;
                st     <= PMCRB_I_ACKR;
              end else begin
                wr_o <= 1'b1;
                st   <= PMCRB_I_ACKW;
              end
            end
          end
          PMCRB_I_ACKA, PMCRB_I_ACKR, PMCRB_I_ACKW, PMCRB_I_RWAIT: begin
            if (fall) begin
              sda_oe_o <= 1'b0;
              cnt      <= 4'h0;
              if ((st == PMCRB_I_ACKA && sh[0]) || st == PMCRB_I_RWAIT) begin
                sh       <= rdata_i;
                sda_oe_o <= ~rdata_i[7];
                addr_o   <= addr_o + 8'h01;
                st       <= PMCRB_I_RDATA;
              end else if (st == PMCRB_I_ACKA) begin
                st <= PMCRB_I_REG;
              end else begin
                if (st == PMCRB_I_ACKW) begin
                  addr_o <= addr_o + 8'h01;
                end
                st <= PMCRB_I_WDATA;
              end
            end
          end
          PMCRB_I_RDATA: begin
            if (rise) begin
              cnt <= cnt + 4'h1;
            end else if (fall) begin
              if (cnt == `PMCRB_BYTE_BITS) begin
                sda_oe_o <= 1'b0;
                st       <= PMCRB_I_MACK;
              end else begin
                sh       <= {sh[6:0], 1'b0};
                sda_oe_o <= ~sh[6];
              end
            end
          end
          PMCRB_I_MACK: begin
            if (rise) begin
              st <= sda_i ? PMCRB_I_IDLE : PMCRB_I_RWAIT;
            end
          end
          default: begin
            st <= PMCRB_I_IDLE;
          end
        endcase
      end
    end
  end

endmodule : pmcrb_i2c_slave

// File: core/pmcrb_reg_bank.sv
`timescale 1ns/100ps
`include "pmcrb_consts.svh"
module pmcrb_reg_bank #(
  parameter logic [6:0] DEV_ADDR = `PMCRB_I2C_ADDR,
  // arbitrary identification values
  parameter logic [7:0] PROD_ID  = `PMCRB_PROD_ID,
  parameter logic [7:0] REV_ID   = `PMCRB_REV_ID
) (
  input  wire logic                       clk_i,
  input  wire logic                       resetn_i,
  input  wire logic                       scl_i,
  input  wire logic                       sda_i,
  input  wire logic [`PMCRB_NFAULT-1:0]   fault_i,
  input  wire logic [`PMCRB_NFUSE-1:0]    fuse_code_i,
  output logic                            sda_o,
  output logic                            sda_oe_o,
  output logic [`PMCRB_NFAULT-1:0]        irq_src_o,
  output logic                            buck_mode_select_o,
  output logic                            buck_on_o,
  output logic [3:0]                      linreg_on_o,
  output logic [4:0]                      discharge_en_o,
  output logic                            powerup_start_o,
  output pmcrb_pkg::pmcrb_tsd_e           tsd_state_o
);
  import pmcrb_pkg::*;

  localparam int NS = 2 + `PMCRB_NFAULT + `PMCRB_NFUSE;

  if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : g_chk
    $error("pmcrb_reg_bank: DEV_ADDR lies in a reserved range");
  end

  // ******************************
  // pin synchronisers and serial port
  // ******************************
  logic [NS-1:0]              sync_q;
  logic                       scl_n, sda_n;
  logic                       scl_s;
  logic                       sda_s;
  logic [`PMCRB_NFAULT-1:0]   fault_s;
  logic [`PMCRB_NFUSE-1:0]    fuse_s;
  logic                       wr;
  logic [7:0]                 addr;
  logic [7:0]                 wdata;
  logic [7:0]                 rdata;
  logic                       oe;

  pmcrb_sync #(
    .WIDTH (NS)
  ) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      ({~scl_i, ~sda_i, fault_i, fuse_code_i}),
    .q_o      (sync_q)
  );

  // bus lines travel inverted so a synchroniser in reset reads as an idle, high bus
  assign {scl_n, sda_n, fault_s, fuse_s} = sync_q;
  assign scl_s = ~scl_n;
  assign sda_s = ~sda_n;

  pmcrb_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .scl_i    (scl_s),
    .sda_i    (sda_s),
    .rdata_i  (rdata),
    .sda_oe_o (oe),
    .wr_o     (wr),
    .addr_o   (addr),
    .wdata_o  (wdata)
  );

  assign sda_oe_o = oe;

  // open drain: only ever pulls low
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // ******************************
  // register state
  // ******************************
  logic [7:0] irq_mask;
  logic [1:0] policy;
  logic       rst_flag;
  logic [7:0] en_reg;
  logic [7:0] dis_reg;
  logic [7:0] feat_reg;
  logic [7:0] en_saved;
  logic [1:0] fuse_cnt;
  logic       tsd_s;
  logic       def_evt;
  logic       soft_rst;
  logic       tsd_enter;
  logic       tsd_keep;
  logic       tsd_def;
  pmcrb_tsd_e tstate;

  assign tsd_s     = fault_s[`PMCRB_NFAULT-1];
  assign soft_rst  = wr && addr == `PMCRB_A_RESET && wdata[`PMCRB_B_FORCE];
  assign tsd_enter = tstate == PMCRB_T_RUN && tsd_s;
  assign tsd_def   = tstate == PMCRB_T_SHUT && !tsd_s
                     && policy == `PMCRB_POL_DEF;
  assign tsd_keep  = tstate == PMCRB_T_SHUT && !tsd_s
                     && policy == `PMCRB_POL_KEEP;
  assign def_evt   = soft_rst || tsd_def;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_mask <= `PMCRB_D_MASK;
    end else if (def_evt) begin
      irq_mask <= `PMCRB_D_MASK;
    end else if (wr && addr == `PMCRB_A_MASK) begin
      irq_mask <= wdata;
    end
  end

  // reload wins over a host write that lands in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      policy   <= `PMCRB_POL_DEF;
      rst_flag <= 1'b1;
    end else if (def_evt) begin
      policy   <= `PMCRB_POL_DEF;
      rst_flag <= 1'b1;
    end else if (wr && addr == `PMCRB_A_RESET) begin
      policy   <= wdata[1:0];
      rst_flag <= wdata[`PMCRB_B_RSTST];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_reg   <= `PMCRB_D_EN;
      en_saved <= `PMCRB_D_EN;
    end else if (def_evt) begin
      en_reg <= `PMCRB_D_EN;
    end else if (tsd_enter) begin
      en_saved <= en_reg;
      en_reg   <= en_reg & ~`PMCRB_EN_PWR;
    end else if (tsd_keep) begin
      en_reg <= en_saved;
    end else if (wr && addr == `PMCRB_A_EN && tstate == PMCRB_T_RUN) begin
      en_reg <= wdata & `PMCRB_W_EN;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dis_reg <= `PMCRB_D_DIS;
    end else if (def_evt) begin
      dis_reg <= `PMCRB_D_DIS;
    end else if (wr && addr == `PMCRB_A_DIS) begin
      dis_reg <= wdata & `PMCRB_W_DIS;
    end
  end

  // fuses are loaded on the first three clocks after reset, then held; the last load comes after the synchroniser has settled
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fuse_cnt <= 2'h0;
      feat_reg <= 8'h00;
    end else if (fuse_cnt != `PMCRB_FUSE_WAIT) begin
      fuse_cnt <= fuse_cnt + 2'h1;
      feat_reg <= fuse_s;
    end
  end

  // ******************************
  // thermal shutdown recovery
  // ******************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tstate <= PMCRB_T_RUN;
    end else begin
      unique case (tstate)
        PMCRB_T_RUN: begin
          if (tsd_s) begin
            tstate <= PMCRB_T_SHUT;
          end
        end
        PMCRB_T_SHUT: begin
          if (!tsd_s) begin
            // code 11 is treated like 10: safest is to stay off
            tstate <= policy[1] ? PMCRB_T_LATCH : PMCRB_T_RUN;
          end
        end
        PMCRB_T_LATCH: begin
          tstate <= PMCRB_T_LATCH;
        end
        default: begin
          tstate <= PMCRB_T_LATCH;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      powerup_start_o <= 1'b0;
      tsd_state_o     <= PMCRB_T_RUN;
    end else begin
      powerup_start_o <= tsd_def || tsd_keep;
      tsd_state_o     <= tstate;
    end
  end

  // ******************************
  // outputs to the analog side
  // ******************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_src_o <= '0;
    end else begin
      irq_src_o[4:0] <= fault_s[4:0] & ~irq_mask[4:0];
      irq_src_o[5]   <= fault_s[5] & ~irq_mask[5];
      irq_src_o[6]   <= fault_s[6] & ~irq_mask[6];
      irq_src_o[7]   <= fault_s[7] & ~irq_mask[7];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      buck_mode_select_o <= 1'b0;
      buck_on_o          <= 1'b0;
      linreg_on_o        <= 4'h0;
      discharge_en_o     <= 5'h00;
    end else begin
      buck_mode_select_o <= en_reg[`PMCRB_B_MODE];
      buck_on_o          <= en_reg[`PMCRB_B_BUCK];
      linreg_on_o        <= en_reg[5:2];
      discharge_en_o     <= dis_reg[4:0];
    end
  end

  // ******************************
  // read mux
  // ******************************
  always_comb begin
    rdata = 8'h00;
    unique case (addr)
      `PMCRB_A_MASK:  rdata = irq_mask;
      `PMCRB_A_RESET: rdata = {3'h0, rst_flag, 2'h0, policy};
      `PMCRB_A_PROD:  rdata = PROD_ID;
      `PMCRB_A_REV:   rdata = REV_ID;
      `PMCRB_A_FEAT:  rdata = feat_reg;
      `PMCRB_A_EN:    rdata = en_reg;
      `PMCRB_A_DIS:   rdata = dis_reg;
      default:        rdata = 8'h00;
    endcase
  end

  // ******************************
  // assertions
  // ******************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_oc_mask;
    ((fault_s[4:0] & irq_mask[4:0]) != 5'h00) && !def_evt && !wr
      |=> ((irq_src_o[4:0] & irq_mask[4:0]) == 5'h00);
  endproperty
  a_oc_mask: assert property (p_oc_mask) else $error("masked over-current reached");

  property p_uv_mask;
    fault_s[5] && !irq_mask[5] |=> irq_src_o[5];
  endproperty
  a_uv_mask: assert property (p_uv_mask) else $error("undervoltage not passed");

  property p_warn_mask;
    irq_mask[6] && !def_evt && !wr |=> !irq_src_o[6];
  endproperty
  a_warn_mask: assert property (p_warn_mask) else $error("masked warning passed");

  property p_tsd_mask;
    fault_s[7] && !irq_mask[7] |=> irq_src_o[7];
  endproperty
  a_tsd_mask: assert property (p_tsd_mask) else $error("shutdown irq not passed");

  property p_thermal_restart_policy_def;
    tsd_def |=> en_reg == `PMCRB_D_EN && rst_flag && irq_mask == `PMCRB_D_MASK
      && powerup_start_o;
  endproperty
  a_thermal_restart_policy_def: assert property (p_thermal_restart_policy_def) else $error("default thermal_restart_policy wrong");

  property p_thermal_restart_policy_keep;
    tsd_keep |=> en_reg == $past(en_saved) && powerup_start_o;
  endproperty
  a_thermal_restart_policy_keep: assert property (p_thermal_restart_policy_keep) else $error("keep thermal_restart_policy wrong");

  property p_no_thermal_restart_policy;
    tstate == PMCRB_T_LATCH |=> tstate == PMCRB_T_LATCH && !powerup_start_o;
  endproperty
  a_no_thermal_restart_policy: assert property (p_no_thermal_restart_policy) else $error("restarted while latched");

  property p_force;
    soft_rst |=> rst_flag && irq_mask == `PMCRB_D_MASK && dis_reg == `PMCRB_D_DIS
      && policy == `PMCRB_POL_DEF;
  endproperty
  a_force: assert property (p_force) else $error("forced reset incomplete");

  property p_prod;
    addr == `PMCRB_A_PROD |-> rdata == PROD_ID;
  endproperty
  a_prod: assert property (p_prod) else $error("product code wrong");

  property p_spare;
    (rdata & ~`PMCRB_W_EN) == 8'h00 || addr == `PMCRB_A_MASK || addr[7:2] == 6'h0C;
  endproperty
  a_spare: assert property (p_spare) else $error("spare bits nonzero");

  property p_buck_on;
    en_reg[`PMCRB_B_BUCK] ##1 en_reg[`PMCRB_B_BUCK] |-> buck_on_o;
  endproperty
  a_buck_on: assert property (p_buck_on) else $error("buck enable not driven");

  c_soft_rst: cover property (soft_rst);
  c_thermal_restart_policy_keep: cover property (tsd_keep);
  c_latched: cover property (tstate == PMCRB_T_LATCH);
  c_reg_write: cover property (wr && addr == `PMCRB_A_EN);

endmodule : pmcrb_reg_bank

// File: tb/pmcrb_host_model.sv
`timescale 1ns/100ps
`include "pmcrb_consts.svh"
module pmcrb_host_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  // ********
  // bus phases
  // ********
  // idle bus: clock high, data released to the pull-up
  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  // six clocks per phase, above the four the device sampler needs
  task automatic gap();
    repeat (6) @(posedge clk_i);
    #1;
  endtask : gap

  // data is changed only while the clock is low, never on its edge
  task automatic bit_io(input logic v, output logic s);
    sda_pull_o = ~v;
    gap();
    scl_o = 1'b1;
    gap();
    s     = sda_i;
    scl_o = 1'b0;
    gap();
  endtask : bit_io

  task automatic start();
    sda_pull_o = 1'b0;
    gap();
    scl_o = 1'b1;
    gap();
    sda_pull_o = 1'b1;
    gap();
    scl_o = 1'b0;
    gap();
  endtask : start

  task automatic stop();
    sda_pull_o = 1'b1;
    gap();
    scl_o = 1'b1;
    gap();
    sda_pull_o = 1'b0;
    gap();
  endtask : stop

  // ********
  // transfers
  // ********
  task automatic send(input logic [7:0] b, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ok = ok & (s === 1'b0);
  endtask : send

  // one register access; a read ends with a nack on its single byte
  task automatic xfer(input logic [6:0] dev, input logic [7:0] ra, input logic rd,
                      input logic [7:0] wd, output logic [7:0] rdat, output logic ok);
    logic s;
    ok   = 1'b1;
    rdat = 8'h00;
    start();
    send({dev, 1'b0}, ok);
    send(ra, ok);
    if (rd) begin
      start();
      send({dev, 1'b1}, ok);
      for (int i = 7; i >= 0; i--) begin
        bit_io(1'b1, s);
        rdat[i] = s;
      end
      bit_io(1'b1, s);
    end else begin
      send(wd, ok);
    end
    stop();
  endtask : xfer
endmodule : pmcrb_host_model

// File: tb/tb_pmcrb_reg_bank.sv
`timescale 1ns/100ps
`include "pmcrb_consts.svh"
module tb_pmcrb_reg_bank;
  import pmcrb_pkg::*;
  localparam logic [7:0] FUSE = 8'hA5;
  logic       clk_i  = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] fault  = 8'h00;
  logic       scl, sda_pull, sda_o, sda_oe, buck_mode, buck_on, powerup;
  logic [7:0] irq;
  logic [3:0] linreg_on;
  logic [4:0] dis_en;
  pmcrb_tsd_e thermal_shutdown_event;
  wire        sda = ~sda_pull & ~(sda_oe & ~sda_o);
  int         n_mismatch = 0;
  int         n_checks   = 0;

  always #5 clk_i = ~clk_i;

  pmcrb_reg_bank pmcrb_reg_bank_inst (
    .clk_i (clk_i), .resetn_i (resetn), .scl_i (scl), .sda_i (sda), .fault_i (fault),
    .fuse_code_i (FUSE), .sda_o (sda_o), .sda_oe_o (sda_oe), .irq_src_o (irq),
    .buck_mode_select_o (buck_mode), .buck_on_o (buck_on), .linreg_on_o (linreg_on),
    .discharge_en_o (dis_en), .powerup_start_o (powerup), .tsd_state_o (thermal_shutdown_event));

  pmcrb_host_model pmcrb_host_model_inst (
    .clk_i (clk_i), .sda_i (sda), .scl_o (scl), .sda_pull_o (sda_pull));

  // ********
  // helpers
  // ********
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       ok;
    pmcrb_host_model_inst.xfer(`PMCRB_I2C_ADDR, a, 1'b0, d, r, ok);
    chk("write ack", {7'h00, ok}, 8'h01);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    logic       ok;
    pmcrb_host_model_inst.xfer(`PMCRB_I2C_ADDR, a, 1'b1, 8'h00, r, ok);
    chk(what, r, exp);
  endtask : rdc

  task automatic do_reset();
    resetn = 1'b0;
    tick(2);
    resetn = 1'b1;
    tick(4);
  endtask : do_reset

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // ********
  // scenarios
  // ********
  task automatic t_defaults();
    rdc("mask", `PMCRB_A_MASK, 8'hFF);
    rdc("reset ctrl", `PMCRB_A_RESET, 8'h10);
    rdc("product", `PMCRB_A_PROD, `PMCRB_PROD_ID);
    rdc("revision", `PMCRB_A_REV, `PMCRB_REV_ID);
    rdc("feature", `PMCRB_A_FEAT, FUSE);
    rdc("enable", `PMCRB_A_EN, 8'h3E);
    rdc("discharge", `PMCRB_A_DIS, 8'h00);
    chk("buck on", {7'h00, buck_on}, 8'h01);
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_fields();
    logic [7:0] r;
    logic       ok;
    wr(`PMCRB_A_EN, 8'h01);
    chk("mode", {7'h00, buck_mode}, 8'h01);
    chk("buck on", {7'h00, buck_on}, 8'h00);
    chk("linreg on", {4'h0, linreg_on}, 8'h00);
    wr(`PMCRB_A_EN, 8'hFE);
    rdc("enable spare", `PMCRB_A_EN, 8'h3E);
    chk("linreg on", {4'h0, linreg_on}, 8'h0F);
    chk("mode", {7'h00, buck_mode}, 8'h00);
    wr(`PMCRB_A_DIS, 8'hFF);
    rdc("discharge spare", `PMCRB_A_DIS, 8'h1F);
    wr(`PMCRB_A_DIS, 8'h0A);
    chk("discharge", {3'h0, dis_en}, 8'h0A);
    wr(`PMCRB_A_RESET, 8'h6E);
    rdc("reset ctrl", `PMCRB_A_RESET, 8'h02);
    wr(`PMCRB_A_PROD, 8'hFF);
    rdc("product ro", `PMCRB_A_PROD, `PMCRB_PROD_ID);
    wr(8'h40, 8'hFF);
    rdc("unmapped", 8'h40, 8'h00);
    pmcrb_host_model_inst.xfer(7'h2D, `PMCRB_A_EN, 1'b0, 8'h00, r, ok);
    chk("foreign ack", {7'h00, ok}, 8'h00);
    $display("test fields done");
  endtask : t_fields

  task automatic t_mask();
    for (int i = 0; i < 7; i++) begin
      fault = 8'h01 << i;
      tick(4);
      chk("irq masked", irq, 8'h00);
      wr(`PMCRB_A_MASK, ~(8'h01 << i));
      chk("irq open", irq, 8'h01 << i);
    end
    fault = 8'h00;
    $display("test mask done");
  endtask : t_mask

  task automatic t_force();
    wr(`PMCRB_A_EN, 8'h00);
    wr(`PMCRB_A_RESET, 8'h80);
    rdc("reset ctrl", `PMCRB_A_RESET, 8'h10);
    rdc("enable", `PMCRB_A_EN, 8'h3E);
    rdc("mask", `PMCRB_A_MASK, 8'hFF);
    rdc("discharge", `PMCRB_A_DIS, 8'h00);
    $display("test force done");
  endtask : t_force

  task automatic t_thermal(input logic [1:0] pol);
    logic got;
    wr(`PMCRB_A_RESET, {6'h00, pol});
    wr(`PMCRB_A_EN, 8'h07);
    wr(`PMCRB_A_MASK, 8'hFF);
    fault = 8'h80;
    tick(6);
    chk("tsd state", {5'h00, thermal_shutdown_event}, {5'h00, PMCRB_T_SHUT});
    chk("irq tsd blocked", irq, 8'h00);
    wr(`PMCRB_A_MASK, 8'h7F);
    chk("irq tsd", irq, 8'h80);
    // a host write during shutdown must not switch rails back on
    wr(`PMCRB_A_EN, 8'h3F);
    rdc("enable in tsd", `PMCRB_A_EN, 8'h01);
    fault = 8'h00;
    got   = 1'b0;
    for (int i = 0; i < 20; i++) begin
      tick(1);
      got = got | (powerup === 1'b1);
    end
    chk("powerup", {7'h00, got}, {7'h00, ~pol[1]});
    if (pol == 2'b00) begin
      rdc("enable", `PMCRB_A_EN, 8'h3E);
      rdc("reset ctrl", `PMCRB_A_RESET, 8'h10);
    end else if (pol == 2'b01) begin
      rdc("enable", `PMCRB_A_EN, 8'h07);
      rdc("reset ctrl", `PMCRB_A_RESET, 8'h01);
    end else begin
      chk("tsd state", {5'h00, thermal_shutdown_event}, {5'h00, PMCRB_T_LATCH});
      chk("buck on", {7'h00, buck_on}, 8'h00);
      do_reset();
    end
    $display("test thermal %b done", pol);
  endtask : t_thermal

  // ********
  // sequence
  // ********
  initial begin
    do_reset();
    t_defaults();
    t_fields();
    t_mask();
    t_force();
    for (int p = 0; p < 4; p++) begin
      t_thermal(2'(p));
    end
    summarize();
  end

  initial begin
    repeat (80000) @(posedge clk_i);
    n_mismatch++;
    $display("watchdog expired");
    summarize();
  end
endmodule : tb_pmcrb_reg_bank
